// [pci_sec_params.svh]
// constants for the secondary bus signalling block
// assumes a 32-bit multiplexed bus with four command/byte-enable lines
`ifndef PCI_SEC_PARAMS_SVH
`define PCI_SEC_PARAMS_SVH
`define BUS_DEVSEL_WAIT   3'h5
`define BUS_CMD_MEM_GROUP 3'h3
`define BUS_CMD_WRITE_BIT 0
`define BUS_PARK_AD       32'h00000000
`define BUS_PARK_CBE      4'h0
`define BUS_MAILBOX_RESET 32'h00000000
`endif

// [pci_sec_pkg.sv]
// state types for the secondary bus signalling block
// assumes pci_sec_params.svh carries the numeric constants
package pci_sec_pkg;
	typedef enum logic [1:0] {I_IDLE, I_ADDR, I_DATA, I_TURN} init_state_e;
	typedef enum logic [1:0] {T_IDLE, T_WAIT, T_DATA, T_TURN} target_state_e;
endpackage

// [pci_sec_bus.sv]
// secondary bus signalling: initiator, target mailbox, parking and parity
// assumes bus pins are synchronous to busClock and resolved by the surroundings
`timescale 1ns/10ps
`include "pci_sec_params.svh"

module pci_sec_bus
	import pci_sec_pkg::*;
#(
	parameter logic [31:0] TARGET_BASE = 32'h10000000,
	parameter logic [31:0] TARGET_MASK = 32'hFFFFF000,
	parameter int          CLOCK_HALF  = 4
)(
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic        busClock,
	input  wire logic        reqStart,
	input  wire logic [3:0]  reqCmd,
	input  wire logic [31:0] reqAddr,
	input  wire logic [31:0] reqWriteData,
	input  wire logic [3:0]  reqByteEnable_b,
	output logic             reqBusy,
	output logic             reqDone,
	output logic [31:0]      reqReadData,
	output logic             reqMasterAbort,
	output logic             reqTargetStop,
	output logic             secondaryBusClockOut,
	input  wire logic        gnt_b,
	input  wire logic [31:0] adIn,
	output logic [31:0]      adOut,
	output logic             adOe,
	input  wire logic [3:0]  cbeIn_b,
	output logic [3:0]       cbeOut_b,
	output logic             cbeOe,
	input  wire logic        parIn,
	output logic             parOut,
	output logic             parOe,
	input  wire logic        frameIn_b,
	output logic             frameOut_b,
	output logic             frameOe,
	input  wire logic        irdyIn_b,
	output logic             irdyOut_b,
	output logic             irdyOe,
	input  wire logic        trdyIn_b,
	output logic             trdyOut_b,
	output logic             trdyOe,
	input  wire logic        devselIn_b,
	output logic             devselOut_b,
	output logic             devselOe,
	input  wire logic        stopIn_b,
	output logic             stopOut_b,
	output logic             stopOe
);
	logic [31:0]   holdAddr;
	logic [31:0]   holdData;
	logic [3:0]    holdCmd;
	logic [3:0]    holdBe_b;
	logic          reqToggle;
	logic [1:0]    doneSync;
	logic          doneSeen;
	logic [7:0]    divCount;
	logic [1:0]    busRstSync;
	logic          busRst_b;
	logic [1:0]    reqSync;
	logic          reqSeen;
	logic          pending;
	logic          doneToggle;
	logic [31:0]   iReadData;
	logic          iAbort;
	logic          iStop;
	logic [2:0]    devselCount;
	logic          devselSeen;
	logic          iWrite;
	logic          tWrite;
	logic          frameWasHigh;
	logic          addrHit;
	logic          parkNow;
	logic          timeout;
	logic          iXfer;
	logic          tXfer;
	logic [31:0]   mailbox;
	init_state_e   iState;
	init_state_e   next_iState;
	target_state_e tState;
	target_state_e next_tState;

	function automatic logic even_parity(input logic [31:0] ad, input logic [3:0] cbe);
		even_parity = ^{ad, cbe};
	endfunction

	// core side request capture and completion
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			reqBusy <= 1'b0;
			reqDone <= 1'b0;
			reqToggle <= 1'b0;
			doneSeen <= 1'b0;
			holdAddr <= 32'h00000000;
			holdData <= 32'h00000000;
			holdCmd <= 4'h0;
			holdBe_b <= 4'hF;
			reqReadData <= 32'h00000000;
			reqMasterAbort <= 1'b0;
			reqTargetStop <= 1'b0;
		end
		else
		begin
			reqDone <= 1'b0;
			if (reqStart && !reqBusy)
			begin
				holdAddr <= reqAddr;
				holdData <= reqWriteData;
				holdCmd <= reqCmd;
				holdBe_b <= reqByteEnable_b;
				reqToggle <= ~reqToggle;
				reqBusy <= 1'b1;
			end
			else if (doneSync[1] != doneSeen)
			begin
				doneSeen <= doneSync[1];
				reqBusy <= 1'b0;
				reqDone <= 1'b1;
				reqReadData <= iReadData;
				reqMasterAbort <= iAbort;
				reqTargetStop <= iStop;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			doneSync <= 2'h0;
		else
			doneSync <= {doneSync[0], doneToggle};
	end

	// bus clock divider from the core clock
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			divCount <= 8'h00;
			secondaryBusClockOut <= 1'b0;
		end
		else if (divCount == 8'(CLOCK_HALF - 1))
		begin
			divCount <= 8'h00;
			secondaryBusClockOut <= ~secondaryBusClockOut;
		end
		else
			divCount <= divCount + 8'h01;
	end

	always_ff @(posedge busClock or negedge rst_b)
	begin
		if (!rst_b)
			busRstSync <= 2'h0;
		else
			busRstSync <= {busRstSync[0], 1'b1};
	end
	assign busRst_b = busRstSync[1];

	always_ff @(posedge busClock or negedge busRst_b)
	begin
		if (!busRst_b)
			reqSync <= 2'h0;
		else
			reqSync <= {reqSync[0], reqToggle};
	end

	assign pending = reqSync[1] != reqSeen;
	assign iWrite = holdCmd[`BUS_CMD_WRITE_BIT];
	assign timeout = !devselSeen && devselIn_b && devselCount == `BUS_DEVSEL_WAIT;
	assign iXfer = iState == I_DATA && !irdyIn_b && !trdyIn_b;
	assign tXfer = tState == T_DATA && !irdyIn_b && !trdyIn_b;
	assign addrHit = !frameIn_b && frameWasHigh && iState != I_ADDR && tState == T_IDLE
		&& (adIn & TARGET_MASK) == TARGET_BASE && cbeIn_b[3:1] == `BUS_CMD_MEM_GROUP;
	assign parkNow = next_iState == I_IDLE && next_tState == T_IDLE && !gnt_b && frameIn_b && irdyIn_b;

	always_comb
	begin
		next_iState = iState;
		unique case (iState)
			I_IDLE:
				if (pending && !gnt_b && frameIn_b && irdyIn_b && tState == T_IDLE)
					next_iState = I_ADDR;
			I_ADDR:
				next_iState = I_DATA;
			I_DATA:
				if (iXfer || !stopIn_b || timeout)
					next_iState = I_TURN;
			I_TURN:
				next_iState = I_IDLE;
		endcase
	end

	always_comb
	begin
		next_tState = tState;
		unique case (tState)
			T_IDLE:
				if (addrHit)
					next_tState = cbeIn_b[`BUS_CMD_WRITE_BIT] ? T_DATA : T_WAIT;
			T_WAIT:
				next_tState = T_DATA;
			T_DATA:
				if (tXfer && frameIn_b)
					next_tState = T_TURN;
			T_TURN:
				next_tState = T_IDLE;
		endcase
	end

	always_ff @(posedge busClock or negedge busRst_b)
	begin
		if (!busRst_b)
		begin
			iState <= I_IDLE;
			tState <= T_IDLE;
			frameWasHigh <= 1'b1;
		end
		else
		begin
			iState <= next_iState;
			tState <= next_tState;
			frameWasHigh <= frameIn_b;
		end
	end

	// initiator results and handshake back
	always_ff @(posedge busClock or negedge busRst_b)
	begin
		if (!busRst_b)
		begin
			reqSeen <= 1'b0;
			doneToggle <= 1'b0;
			iReadData <= 32'h00000000;
			iAbort <= 1'b0;
			iStop <= 1'b0;
			devselCount <= 3'h0;
			devselSeen <= 1'b0;
		end
		else
		begin
			if (iState == I_ADDR)
			begin
				reqSeen <= reqSync[1];
				devselCount <= 3'h1;
				devselSeen <= 1'b0;
				iAbort <= 1'b0;
				iStop <= 1'b0;
			end
			else if (iState == I_DATA)
			begin
				devselCount <= devselCount + 3'h1;
				devselSeen <= devselSeen || !devselIn_b;
				if (iXfer && !iWrite)
					iReadData <= adIn;
				if (timeout)
					iAbort <= 1'b1;
				if (!stopIn_b && trdyIn_b)
					iStop <= 1'b1;
			end
			if (iState == I_TURN)
				doneToggle <= ~doneToggle;
		end
	end

	// target mailbox, byte lanes by enables
	generate
		for (genvar b = 0; b < 4; b++)
		begin : g_lane
			always_ff @(posedge busClock or negedge busRst_b)
			begin
				if (!busRst_b)
					mailbox[8*b +: 8] <= 8'(`BUS_MAILBOX_RESET >> (8*b));
				else if (tXfer && tWrite && !cbeIn_b[b])
					mailbox[8*b +: 8] <= adIn[8*b +: 8];
			end
		end
	endgenerate

	always_ff @(posedge busClock or negedge busRst_b)
	begin
		if (!busRst_b)
			tWrite <= 1'b0;
		else if (addrHit)
			tWrite <= cbeIn_b[`BUS_CMD_WRITE_BIT];
	end

	// framing outputs from bus clock flops
	always_ff @(posedge busClock or negedge busRst_b)
	begin
		if (!busRst_b)
		begin
			frameOut_b <= 1'b1;
			frameOe <= 1'b0;
			irdyOut_b <= 1'b1;
			irdyOe <= 1'b0;
		end
		else
		begin
			// single phase, FRAME# drops at last
			frameOut_b <= next_iState != I_ADDR;
			// high for one cycle before release
			frameOe <= next_iState == I_ADDR || (next_iState == I_DATA && iState == I_ADDR);
			irdyOut_b <= next_iState != I_DATA;
			irdyOe <= next_iState == I_DATA || next_iState == I_TURN;
		end
	end

	always_ff @(posedge busClock or negedge busRst_b)
	begin
		if (!busRst_b)
		begin
			trdyOut_b <= 1'b1;
			trdyOe <= 1'b0;
			devselOut_b <= 1'b1;
			devselOe <= 1'b0;
			stopOut_b <= 1'b1;
			stopOe <= 1'b0;
		end
		else
		begin
			trdyOut_b <= next_tState != T_DATA;
			trdyOe <= next_tState != T_IDLE;
			devselOut_b <= next_tState == T_IDLE || next_tState == T_TURN;
			devselOe <= next_tState != T_IDLE;
			stopOut_b <= 1'b1;
			stopOe <= next_tState != T_IDLE;
		end
	end

	// address, data and command drive
	always_ff @(posedge busClock or negedge busRst_b)
	begin
		if (!busRst_b)
		begin
			adOut <= `BUS_PARK_AD;
			adOe <= 1'b0;
			cbeOut_b <= `BUS_PARK_CBE;
			cbeOe <= 1'b0;
		end
		else if (next_iState == I_ADDR)
		begin
			adOut <= holdAddr;
			adOe <= 1'b1;
			cbeOut_b <= holdCmd;
			cbeOe <= 1'b1;
		end
		else if (next_iState == I_DATA)
		begin
			adOut <= holdData;
			adOe <= iWrite;
			cbeOut_b <= holdBe_b;
			cbeOe <= 1'b1;
		end
		else if (next_tState == T_DATA && !tWrite && tState != T_IDLE)
		begin
			adOut <= mailbox;
			adOe <= 1'b1;
			cbeOe <= 1'b0;
		end
		// parked bus held at valid levels
		else if (parkNow)
		begin
			adOut <= `BUS_PARK_AD;
			adOe <= 1'b1;
			cbeOut_b <= `BUS_PARK_CBE;
			cbeOe <= 1'b1;
		end
		else
		begin
			adOe <= 1'b0;
			cbeOe <= 1'b0;
		end
	end

	// parity one clock behind the bus
	always_ff @(posedge busClock or negedge busRst_b)
	begin
		if (!busRst_b)
		begin
			parOut <= 1'b0;
			parOe <= 1'b0;
		end
		else
		begin
			parOut <= even_parity(adIn, cbeIn_b);
			parOe <= (adOe && !(iWrite && (iState == I_ADDR || iState == I_DATA || next_iState == I_ADDR)))
				|| (tWrite && tState == T_DATA) || addrHit;
		end
	end

	sequence s_frameStart;
		$rose(frameOe) && !frameOut_b;
	endsequence

	sequence s_frameEnd;
		(frameOe && frameOut_b) ##1 !frameOe;
	endsequence

	property p_addrPhase;
		@(posedge busClock) disable iff (!busRst_b)
		s_frameStart |-> adOe && adOut == holdAddr && cbeOe && cbeOut_b == holdCmd;
	endproperty
	a_addrPhase: assert property (p_addrPhase) else $error("address not on bus at frame start");

	property p_readCapture;
		@(posedge busClock) disable iff (!busRst_b)
		iXfer && !iWrite |=> iReadData == $past(adIn);
	endproperty
	a_readCapture: assert property (p_readCapture) else $error("read word not captured");

	property p_park;
		@(posedge busClock) disable iff (!busRst_b)
		parkNow ##1 parkNow |-> adOe && cbeOe && adOut == `BUS_PARK_AD ##1 parOe;
	endproperty
	a_park: assert property (p_park) else $error("parked bus not driven");

	property p_byteEnable;
		@(posedge busClock) disable iff (!busRst_b)
		iState == I_DATA |-> cbeOe && cbeOut_b == holdBe_b;
	endproperty
	a_byteEnable: assert property (p_byteEnable) else $error("byte enables wrong in data phase");

	property p_parity;
		@(posedge busClock) disable iff (!busRst_b)
		parOe |-> parOut == ^{$past(adIn), $past(cbeIn_b)};
	endproperty
	a_parity: assert property (p_parity) else $error("parity not even");

	property p_initWritePar;
		@(posedge busClock) disable iff (!busRst_b)
		iState == I_ADDR && iWrite |=> !parOe ##1 !parOe;
	endproperty
	a_initWritePar: assert property (p_initWritePar) else $error("parity driven as write initiator");

	property p_tgtWritePar;
		@(posedge busClock) disable iff (!busRst_b)
		(tState == T_DATA && tWrite) || (addrHit && cbeIn_b[0]) |=> parOe;
	endproperty
	a_tgtWritePar: assert property (p_tgtWritePar) else $error("write target parity missing");

	property p_tgtReadPar;
		@(posedge busClock) disable iff (!busRst_b)
		addrHit && !cbeIn_b[0] |=> parOe ##1 (adOe && !parOe);
	endproperty
	a_tgtReadPar: assert property (p_tgtReadPar) else $error("read target parity timing wrong");

	property p_parRelease;
		@(posedge busClock) disable iff (!busRst_b)
		$fell(adOe) && tState == T_TURN |-> parOe ##1 !parOe;
	endproperty
	a_parRelease: assert property (p_parRelease) else $error("parity not released after data lines");

	property p_frameRelease;
		@(posedge busClock) disable iff (!busRst_b)
		s_frameStart |=> s_frameEnd;
	endproperty
	a_frameRelease: assert property (p_frameRelease) else $error("frame not deasserted one cycle");

	property p_irdyRelease;
		@(posedge busClock) disable iff (!busRst_b)
		$fell(irdyOe) |-> $past(irdyOut_b) && !$past(irdyOut_b, 2);
	endproperty
	a_irdyRelease: assert property (p_irdyRelease) else $error("irdy released without high cycle");

	property p_irdyHold;
		@(posedge busClock) disable iff (!busRst_b)
		iState == I_DATA && next_iState == I_DATA |=> irdyOe && !irdyOut_b;
	endproperty
	a_irdyHold: assert property (p_irdyHold) else $error("irdy dropped before phase end");

	property p_masterAbort;
		@(posedge busClock) disable iff (!busRst_b)
		iState == I_ADDR ##1 (devselIn_b && stopIn_b && trdyIn_b)[*5] |=> iState == I_TURN && iAbort;
	endproperty
	a_masterAbort: assert property (p_masterAbort) else $error("no master abort after devsel wait");

	property p_trdyHold;
		@(posedge busClock) disable iff (!busRst_b)
		tState == T_DATA && !trdyOut_b && irdyIn_b |=> !trdyOut_b && trdyOe;
	endproperty
	a_trdyHold: assert property (p_trdyHold) else $error("trdy dropped before phase end");
endmodule

// [pci_bus_agent.sv]
// far-side agent: target for bridge cycles, initiator into its mailbox
// assumes resolved bus levels on inputs and busClock from the bench
`timescale 1ns/10ps
module pci_bus_agent(
	input	wire logic		busClock,
	input	wire logic		rst_b,
	input	wire logic [1:0]	mode,
	input	wire logic [31:0]	readValue,
	input	wire logic [31:0]	ad,
	input	wire logic [3:0]	cbe_b,
	input	wire logic		par,
	input	wire logic		frame_b,
	input	wire logic		irdy_b,
	input	wire logic		trdy_b,
	input	wire logic		stop_b,
	output	logic [31:0]		agAd = 32'h0,
	output	logic			agAdOe = 1'h0,
	output	logic [3:0]		agCbe_b = 4'h0,
	output	logic			agCbeOe = 1'h0,
	output	logic			agFrame_b = 1'h1,
	output	logic			agFrameOe = 1'h0,
	output	logic			agIrdy_b = 1'h1,
	output	logic			agIrdyOe = 1'h0,
	output	logic			agTrdy_b,
	output	logic			agDevsel_b,
	output	logic			agStop_b,
	output	logic			agTgtOe
);
	logic [31:0]	gotAddr, gotData, readBack;
	logic [3:0]	gotCmd, gotBe;
	logic [1:0]	tState, waitCnt;
	logic		lastFrame, parOk, aborted;

	// mode: 0 prompt, 1 slow, 2 never claims, 3 stops
	always @(posedge busClock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tState <= 2'h0;
			{agTgtOe, agDevsel_b, agTrdy_b, agStop_b} <= 4'h7;
		end
		else
		begin
			lastFrame <= frame_b;
			case (tState)
			2'h0: if (!frame_b && lastFrame && !agFrameOe && mode != 2'h2)
			begin
				gotAddr <= ad;
				gotCmd <= cbe_b;
				{agTgtOe, agDevsel_b, agTrdy_b, agStop_b} <= 4'hB;
				waitCnt <= {mode == 2'h1, 1'h0};
				tState <= 2'h1;
			end
			2'h1: if (waitCnt != 2'h0)
				waitCnt <= waitCnt - 2'h1;
			else
			begin
				agStop_b <= mode != 2'h3;
				agTrdy_b <= mode == 2'h3;
				agAdOe <= !gotCmd[0];
				agAd <= readValue;
				tState <= 2'h2;
			end
			2'h2: if ((!irdy_b && !trdy_b) || !stop_b)
			begin
				gotData <= ad;
				gotBe <= cbe_b;
				{agDevsel_b, agTrdy_b, agStop_b} <= 3'h7;
				agAdOe <= 1'h0;
				tState <= 2'h3;
			end
			default:
			begin
				agTgtOe <= 1'h0;
				tState <= 2'h0;
			end
			endcase
		end
	end

	task automatic initiate(input logic [3:0] cmd, input logic [31:0] addr, input logic [31:0] data,
		input logic [3:0] be);
		int n;
		@(posedge busClock);
		agFrameOe <= 1'h1;
		agFrame_b <= 1'h0;
		agAdOe <= 1'h1;
		agAd <= addr;
		agCbeOe <= 1'h1;
		agCbe_b <= cmd;
		@(posedge busClock);
		agFrame_b <= 1'h1;
		agIrdyOe <= 1'h1;
		agIrdy_b <= 1'h0;
		agCbe_b <= be;
		agAd <= data;
		agAdOe <= cmd[0];
		aborted = 1'h0;
		@(posedge busClock);
		parOk = par === ^{addr, cmd};
		agFrameOe <= 1'h0;
		for (n = 0; trdy_b !== 1'h0 && !aborted; n++)
		begin
			aborted = n >= 4;
			@(posedge busClock);
		end
		readBack = ad;
		agIrdy_b <= 1'h1;
		agAdOe <= 1'h0;
		agCbeOe <= 1'h0;
		@(posedge busClock);
		agIrdyOe <= 1'h0;
	endtask
endmodule

// [pci_secondary_bus_signalling_test.sv]
// bench for the secondary bus signalling block
// assumes pci_bus_agent models the other bus agents
`timescale 1ns/10ps
module pci_secondary_bus_signalling_test;
	logic		clock = 1'h0, busClock = 1'h0, rst_b = 1'h0, reqStart = 1'h0, gnt_b = 1'h1;
	logic [3:0]	reqCmd = 4'h0, reqByteEnable_b = 4'h0, cbeOut_b, cbe_b, agCbe_b, floatCbe = 4'h0;
	logic [31:0]	reqAddr = 32'h0, reqWriteData = 32'h0, reqReadData, adOut, ad, agAd;
	logic [31:0]	floatAd = 32'h0, readValue = 32'h0;
	logic [1:0]	mode = 2'h0;
	logic		reqBusy, reqDone, reqMasterAbort, reqTargetStop, secondaryBusClockOut;
	logic		adOe, cbeOe, parOut, parOe, par, lastPar = 1'h0, lastX = 1'h0;
	logic		frameOut_b, frameOe, irdyOut_b, irdyOe, trdyOut_b, trdyOe, devselOut_b, devselOe;
	logic		stopOut_b, stopOe, frame_b, irdy_b, trdy_b, devsel_b, stop_b;
	logic		agAdOe, agCbeOe, agFrame_b, agFrameOe, agIrdy_b, agIrdyOe;
	logic		agTrdy_b, agDevsel_b, agStop_b, agTgtOe;
	int		n_fail = 0, n_tests = 0, parErr = 0, wrPar = 0;

	always #2 clock = ~clock;
	initial
	begin
		#5;
		forever #24 busClock = ~busClock;
	end

	assign ad = adOe ? adOut : agAdOe ? agAd : floatAd;
	assign cbe_b = cbeOe ? cbeOut_b : agCbeOe ? agCbe_b : floatCbe;
	assign par = parOe ? parOut : ~lastPar;
	assign frame_b = frameOe ? frameOut_b : agFrameOe ? agFrame_b : 1'h1;
	assign irdy_b = irdyOe ? irdyOut_b : agIrdyOe ? agIrdy_b : 1'h1;
	assign trdy_b = trdyOe ? trdyOut_b : agTgtOe ? agTrdy_b : 1'h1;
	assign devsel_b = devselOe ? devselOut_b : agTgtOe ? agDevsel_b : 1'h1;
	assign stop_b = stopOe ? stopOut_b : agTgtOe ? agStop_b : 1'h1;

	pci_sec_bus dut(.clock, .rst_b, .busClock, .reqStart, .reqCmd, .reqAddr, .reqWriteData,
		.reqByteEnable_b, .reqBusy, .reqDone, .reqReadData, .reqMasterAbort, .reqTargetStop,
		.secondaryBusClockOut, .gnt_b, .adIn(ad), .adOut, .adOe, .cbeIn_b(cbe_b), .cbeOut_b, .cbeOe,
		.parIn(par), .parOut, .parOe, .frameIn_b(frame_b), .frameOut_b, .frameOe, .irdyIn_b(irdy_b),
		.irdyOut_b, .irdyOe, .trdyIn_b(trdy_b), .trdyOut_b, .trdyOe, .devselIn_b(devsel_b),
		.devselOut_b, .devselOe, .stopIn_b(stop_b), .stopOut_b, .stopOe);

	pci_bus_agent agent(.busClock, .rst_b, .mode, .readValue, .ad, .cbe_b, .par, .frame_b, .irdy_b,
		.trdy_b, .stop_b, .agAd, .agAdOe, .agCbe_b, .agCbeOe, .agFrame_b, .agFrameOe, .agIrdy_b,
		.agIrdyOe, .agTrdy_b, .agDevsel_b, .agStop_b, .agTgtOe);

	// undriven AD, C/BE# and PAR lines show the inverse of their last level; undriven control lines read high
	always @(posedge busClock)
	begin
		floatAd <= ~ad;
		floatCbe <= ~cbe_b;
		lastPar <= par;
		lastX <= ^{ad, cbe_b};
		if (parOe === 1'h1 && par !== lastX) parErr++;
		if (parOe === 1'h1 && reqCmd[0] && ((irdyOe && !irdyOut_b) || (frameOe && !frameOut_b))) wrPar++;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic busWait(input int k);
		repeat (k) @(posedge busClock);
	endtask

	task automatic req(input logic [3:0] cmd, input logic [31:0] addr, input logic [31:0] data,
		input logic [3:0] be);
		int n;
		@(posedge clock);
		reqStart <= 1'h1;
		reqCmd <= cmd;
		reqAddr <= addr;
		reqWriteData <= data;
		reqByteEnable_b <= be;
		@(posedge clock);
		reqStart <= 1'h0;
		for (n = 0; n < 3000 && reqDone !== 1'h1; n++)
			@(posedge clock);
		chk(n < 3000, 32'h1, "request done");
	endtask

	task automatic testPark;
		time t0;
		@(posedge busClock);
		gnt_b <= 1'h0;
		busWait(4);
		chk({adOe, cbeOe, parOe}, 32'h7, "park drive");
		chk(ad, 32'h0, "park value");
		@(posedge secondaryBusClockOut);
		t0 = $time;
		@(negedge secondaryBusClockOut);
		chk(32'($time - t0), 32'h10, "bus clock half period");
		@(posedge clock);
		rst_b <= 1'h0;
		repeat (30) @(posedge clock);
		chk({adOe, cbeOe, parOe, frameOe, irdyOe, reqBusy}, 32'h0, "reset clear");
		rst_b <= 1'h1;
		busWait(6);
		chk({adOe, cbeOe, parOe}, 32'h7, "park after reset");
		$display("test park done");
	endtask

	task automatic testWrite;
		@(posedge clock);
		mode <= 2'h0;
		req(4'h7, 32'h20000040, 32'hCAFE1234, 4'h3);
		chk(agent.gotAddr, 32'h20000040, "address");
		chk(agent.gotCmd, 4'h7, "command");
		chk(agent.gotBe, 4'h3, "byte enables");
		chk(agent.gotData, 32'hCAFE1234, "write data");
		chk(wrPar, 0, "par driven in write");
		$display("test write done");
	endtask

	task automatic testRead;
		@(posedge clock);
		mode <= 2'h1;
		readValue <= 32'h5A5AC3C3;
		req(4'h6, 32'h20000080, 32'h0, 4'h0);
		chk(reqReadData, 32'h5A5AC3C3, "read data");
		chk(reqMasterAbort, 32'h0, "no abort");
		$display("test read done");
	endtask

	task automatic testEnds;
		@(posedge clock);
		mode <= 2'h2;
		req(4'h6, 32'h30000000, 32'h0, 4'h0);
		chk(reqMasterAbort, 32'h1, "master abort");
		@(posedge clock);
		mode <= 2'h3;
		req(4'h7, 32'h30000004, 32'h1, 4'h0);
		chk({reqTargetStop, reqMasterAbort}, 32'h2, "target stop");
		$display("test abort and stop done");
	endtask

	task automatic testMailbox;
		@(posedge busClock);
		gnt_b <= 1'h1;
		busWait(3);
		agent.initiate(4'h7, 32'h10000008, 32'h11223344, 4'hA);
		chk(agent.aborted, 32'h0, "write claimed");
		chk(agent.parOk, 32'h1, "write target parity");
		agent.initiate(4'h6, 32'h10000008, 32'h0, 4'h0);
		chk(agent.parOk, 32'h1, "read target parity");
		chk(agent.readBack, 32'h00220044, "mailbox lanes");
		agent.initiate(4'h7, 32'h20000000, 32'h0, 4'h0);
		chk(agent.aborted, 32'h1, "miss ignored");
		chk(parErr, 0, "parity errors");
		$display("test mailbox done");
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial
	begin
		repeat (5) @(posedge busClock);
		@(posedge clock);
		rst_b <= 1'h1;
		busWait(4);
		testPark;
		testWrite;
		testRead;
		testEnds;
		testMailbox;
		report_and_stop;
	end

	// whole run needs a few microseconds
	initial
	begin
		#100000;
		n_fail++;
		report_and_stop;
	end
endmodule
